// *** verilog/efb_builder.sv ***
// efb_builder: latches error events, builds emergency frames, sends boot-up.
// assumes a CAN controller that takes one frame on tx_valid_out && tx_ready_in;
// event inputs come from logic on clk_in and are held until taken, details valid with them.
`timescale 1ns/1ps
// Functional notes
// - emergency identifier is 128 plus node identifier.
// - bytes 0-1 code, byte 2 error register, rest additional info.
// - error register bits: 0 generic, 1 current, 2 voltage, 4 comm, 7 maker.
// - frames are sent unprompted as soon as a condition arises.
// - supply overvoltage sends 3110, bit 2, byte 4 channel.
// - supply undervoltage sends 3120, bit 2, module and channel.
// - gateway-own voltage errors report module and channel as zero.
// - field undervoltage sends 3320, bit 2, module and channel.
// - module diagnostics send 7000, bit 7, module, channel, flags.
// - general module error sends 7010, bits 0 and 7, module.
// - counter diagnostic change sends 7011, bits 0 and 7, module.
// - module list changes send 707A, 707D, 707E or 707F, bit 7, module.
// - 8100 with byte 3 of 2 or 3; 8130 for guard failure.
// - leaving bus-off sends 8140, bit 4, other bytes zero.
// - forced-output mode sends 9009, bit 7, other bytes zero.
// - bytes 6 and 7 zero except single-wire 7000.
// - unused additional bytes are zero.
// - single-wire 7000 carries diag bytes 0,1 and two OR groups.
// - after initialization one boot-up frame with one zero byte.
module efb_builder #(
   parameter int DEPTH = efb_pkg::QUEUE_DEPTH
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [6:0] node_id_in,
   input wire logic init_done_in,
   input wire logic ev_supply_high_in,
   input wire logic ev_supply_low_in,
   input wire logic ev_field_low_in,
   input wire logic ev_module_diag_in,
   input wire logic ev_module_err_in,
   input wire logic ev_diag_change_in,
   input wire logic ev_list_adapt_in,
   input wire logic ev_list_incompat_in,
   input wire logic ev_list_expand_in,
   input wire logic ev_list_removed_in,
   input wire logic ev_can_warning_in,
   input wire logic ev_tx_timeout_in,
   input wire logic ev_guard_fail_in,
   input wire logic ev_bus_off_left_in,
   input wire logic forced_output_mode_in,
   input wire logic gateway_source_in,
   input wire logic single_wire_in,
   input wire logic [7:0] module_in,
   input wire logic [7:0] channel_in,
   input wire logic [63:0] diag_in,
   output logic ev_ready_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output logic [10:0] tx_id_out,
   output logic [3:0] tx_dlc_out,
   output logic [63:0] tx_data_out
);
   typedef enum logic [2:0] {
      EFB_IDLE = 3'h1,
      EFB_BOOT = 3'h2,
      EFB_EMCY = 3'h4
   } efb_state_t;

   efb_state_t state;
   logic forced_seen;
   logic forced_rise;
   logic [efb_pkg::SRC_TOTAL-1:0] ev_vec;
   logic any_event;
   logic [63:0] next_frame;
   logic [63:0] head;
   logic q_full;
   logic q_empty;
   logic q_pop;
   logic [15:0] code;
   logic [7:0] err_reg;
   logic [7:0] b3;
   logic [7:0] b4;
   logic [7:0] b5;
   logic [7:0] b6;
   logic [7:0] b7;
   logic [7:0] gw_module;
   logic [7:0] gw_channel;

   // forced mode is a level; only its activation raises a frame. the level is
   // not taken while a higher source wins the cycle, so the activation stays
   // pending instead of being swallowed
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         forced_seen <= 1'b0;
      end else if (ev_ready_out && !(|ev_vec[efb_pkg::SRC_FORCED-1:0])) begin
         forced_seen <= forced_output_mode_in;
      end else if (!forced_output_mode_in) begin
         forced_seen <= 1'b0;
      end
   end
   assign forced_rise = forced_output_mode_in && !forced_seen;

   assign ev_vec = {forced_rise, ev_bus_off_left_in, ev_guard_fail_in, ev_tx_timeout_in,
                    ev_can_warning_in, ev_list_removed_in, ev_list_expand_in,
                    ev_list_incompat_in, ev_list_adapt_in, ev_diag_change_in,
                    ev_module_err_in, ev_module_diag_in, ev_field_low_in,
                    ev_supply_low_in, ev_supply_high_in};
   assign any_event = |ev_vec;
   // the source must hold its event while ready is low, so nothing is lost
   assign ev_ready_out = !q_full;

   // gateway-own voltage faults carry no module or channel number
   assign gw_module = gateway_source_in ? 8'h00 : module_in;
   assign gw_channel = gateway_source_in ? 8'h00 : channel_in;

   // one event per cycle; lowest source number wins if two coincide, the
   // other is expected to be presented again the following cycle
   always_comb begin
      code = 16'h0000;
      err_reg = 8'h00;
      b3 = 8'h00;
      b4 = 8'h00;
      b5 = 8'h00;
      b6 = 8'h00;
      b7 = 8'h00;
      if (ev_vec[efb_pkg::SRC_SUPPLY_HIGH]) begin
         code = efb_pkg::CODE_SUPPLY_HIGH;
         err_reg[efb_pkg::ERR_VOLTAGE_BIT] = 1'b1;
         b4 = gw_channel;
      end else if (ev_vec[efb_pkg::SRC_SUPPLY_LOW]) begin
         code = efb_pkg::CODE_SUPPLY_LOW;
         err_reg[efb_pkg::ERR_VOLTAGE_BIT] = 1'b1;
         b3 = gw_module;
         b4 = gw_channel;
      end else if (ev_vec[efb_pkg::SRC_FIELD_LOW]) begin
         code = efb_pkg::CODE_FIELD_LOW;
         err_reg[efb_pkg::ERR_VOLTAGE_BIT] = 1'b1;
         b3 = gw_module;
         b4 = gw_channel;
      end else if (ev_vec[efb_pkg::SRC_MODULE_DIAG]) begin
         code = efb_pkg::CODE_MODULE_DIAG;
         err_reg[efb_pkg::ERR_MANUF_BIT] = 1'b1;
         b3 = module_in;
         if (single_wire_in) begin
            b4 = diag_in[7:0];
            b5 = diag_in[15:8];
            b6 = diag_in[23:16] | diag_in[39:32] | diag_in[55:48];
            b7 = diag_in[31:24] | diag_in[47:40] | diag_in[63:56];
         end else begin
            b4 = channel_in;
            b5 = diag_in[7:0];
         end
      end else if (ev_vec[efb_pkg::SRC_MODULE_ERR]) begin
         code = efb_pkg::CODE_MODULE_ERR;
         err_reg[efb_pkg::ERR_GENERIC_BIT] = 1'b1;
         err_reg[efb_pkg::ERR_MANUF_BIT] = 1'b1;
         b3 = module_in;
      end else if (ev_vec[efb_pkg::SRC_DIAG_CHANGE]) begin
         code = efb_pkg::CODE_DIAG_CHANGE;
         err_reg[efb_pkg::ERR_GENERIC_BIT] = 1'b1;
         err_reg[efb_pkg::ERR_MANUF_BIT] = 1'b1;
         b3 = module_in;
      end else if (|ev_vec[efb_pkg::SRC_LIST_REMOVED:efb_pkg::SRC_LIST_ADAPT]) begin
         if (ev_vec[efb_pkg::SRC_LIST_ADAPT]) begin
            code = efb_pkg::CODE_LIST_ADAPT;
         end else if (ev_vec[efb_pkg::SRC_LIST_INCOMPAT]) begin
            code = efb_pkg::CODE_LIST_INCOMPAT;
         end else if (ev_vec[efb_pkg::SRC_LIST_EXPAND]) begin
            code = efb_pkg::CODE_LIST_EXPAND;
         end else begin
            code = efb_pkg::CODE_LIST_REMOVED;
         end
         err_reg[efb_pkg::ERR_MANUF_BIT] = 1'b1;
         b3 = module_in;
      end else if (ev_vec[efb_pkg::SRC_WARNING] || ev_vec[efb_pkg::SRC_TX_TIMEOUT]) begin
         code = efb_pkg::CODE_COMM;
         err_reg[efb_pkg::ERR_COMM_BIT] = 1'b1;
         b3 = ev_vec[efb_pkg::SRC_WARNING] ? efb_pkg::COMM_WARNING : efb_pkg::COMM_TX_TIMEOUT;
      end else if (ev_vec[efb_pkg::SRC_GUARD_FAIL]) begin
         code = efb_pkg::CODE_GUARD_FAIL;
         err_reg[efb_pkg::ERR_COMM_BIT] = 1'b1;
      end else if (ev_vec[efb_pkg::SRC_BUS_OFF_LEFT]) begin
         code = efb_pkg::CODE_BUS_OFF_LEFT;
         err_reg[efb_pkg::ERR_COMM_BIT] = 1'b1;
      end else if (ev_vec[efb_pkg::SRC_FORCED]) begin
         code = efb_pkg::CODE_FORCED;
         err_reg[efb_pkg::ERR_MANUF_BIT] = 1'b1;
      end
      // byte 0 in the low lane; code is sent low byte first as on CAN
      next_frame = {b7, b6, b5, b4, b3, err_reg, code[15:8], code[7:0]};
   end

   // queue keeps detection order across simultaneous conditions
   efb_queue #(
      .WIDTH(efb_pkg::FRAME_BITS),
      .DEPTH(DEPTH)
   ) u_queue (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .push_in(any_event && ev_ready_out),
      .push_data_in(next_frame),
      .pop_in(q_pop),
      .head_out(head),
      .full_out(q_full),
      .empty_out(q_empty)
   );
   assign q_pop = (state == EFB_EMCY) && tx_ready_in;

   // sequencer: boot-up once per initialization, then emergencies unprompted
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= EFB_BOOT;
      end else begin
         case (state)
            EFB_BOOT: begin
               if (init_done_in && tx_ready_in) begin
                  state <= EFB_IDLE;
               end
            end
            EFB_IDLE: begin
               if (!q_empty) begin
                  state <= EFB_EMCY;
               end
            end
            EFB_EMCY: begin
               if (tx_ready_in) begin
                  state <= EFB_IDLE;
               end
            end
            default: begin
               state <= EFB_IDLE;
            end
         endcase
      end
   end

   // handshake is combinational; emergency data comes from the queue store, id and length are computed
   assign tx_valid_out = ((state == EFB_BOOT) && init_done_in) || (state == EFB_EMCY);
   always_comb begin
      if (state == EFB_BOOT) begin
         tx_id_out = 11'(efb_pkg::GUARD_ID_BASE + {4'h0, node_id_in});
         tx_dlc_out = efb_pkg::BOOT_DLC;
         tx_data_out = {56'h0, efb_pkg::BOOTUP_BYTE};
      end else begin
         tx_id_out = 11'(efb_pkg::EMCY_ID_BASE + {4'h0, node_id_in});
         tx_dlc_out = efb_pkg::EMCY_DLC;
         tx_data_out = (state == EFB_EMCY) ? head : 64'h0;
      end
   end
endmodule

// *** verilog/efb_pkg.sv ***
// efb_pkg: constants shared by the emergency frame builder and its queue.
// assumes nothing beyond a SystemVerilog compiler.
package efb_pkg;
   // CAN identifier bases
   localparam logic [10:0] EMCY_ID_BASE = 11'h080;
   localparam logic [10:0] GUARD_ID_BASE = 11'h700;
   // error codes
   localparam logic [15:0] CODE_SUPPLY_HIGH = 16'h3110;
   localparam logic [15:0] CODE_SUPPLY_LOW = 16'h3120;
   localparam logic [15:0] CODE_FIELD_LOW = 16'h3320;
   localparam logic [15:0] CODE_MODULE_DIAG = 16'h7000;
   localparam logic [15:0] CODE_MODULE_ERR = 16'h7010;
   localparam logic [15:0] CODE_DIAG_CHANGE = 16'h7011;
   localparam logic [15:0] CODE_LIST_ADAPT = 16'h707A;
   localparam logic [15:0] CODE_LIST_INCOMPAT = 16'h707D;
   localparam logic [15:0] CODE_LIST_EXPAND = 16'h707E;
   localparam logic [15:0] CODE_LIST_REMOVED = 16'h707F;
   localparam logic [15:0] CODE_COMM = 16'h8100;
   localparam logic [15:0] CODE_GUARD_FAIL = 16'h8130;
   localparam logic [15:0] CODE_BUS_OFF_LEFT = 16'h8140;
   localparam logic [15:0] CODE_FORCED = 16'h9009;
   // error register bits
   localparam int ERR_GENERIC_BIT = 0;
   localparam int ERR_CURRENT_BIT = 1;
   localparam int ERR_VOLTAGE_BIT = 2;
   localparam int ERR_COMM_BIT = 4;
   localparam int ERR_MANUF_BIT = 7;
   // byte 3 values for code 8100, and the boot-up data byte
   localparam logic [7:0] COMM_WARNING = 8'h02;
   localparam logic [7:0] COMM_TX_TIMEOUT = 8'h03;
   localparam logic [7:0] BOOTUP_BYTE = 8'h00;
   // frame lengths
   localparam logic [3:0] EMCY_DLC = 4'h8;
   localparam logic [3:0] BOOT_DLC = 4'h1;
   // event source numbers, also the fixed scan order
   localparam int SRC_COUNT = 14;
   localparam int SRC_SUPPLY_HIGH = 0;
   localparam int SRC_SUPPLY_LOW = 1;
   localparam int SRC_FIELD_LOW = 2;
   localparam int SRC_MODULE_DIAG = 3;
   localparam int SRC_MODULE_ERR = 4;
   localparam int SRC_DIAG_CHANGE = 5;
   localparam int SRC_LIST_ADAPT = 6;
   localparam int SRC_LIST_INCOMPAT = 7;
   localparam int SRC_LIST_EXPAND = 8;
   localparam int SRC_LIST_REMOVED = 9;
   localparam int SRC_WARNING = 10;
   localparam int SRC_TX_TIMEOUT = 11;
   localparam int SRC_GUARD_FAIL = 12;
   localparam int SRC_BUS_OFF_LEFT = 13;
   localparam int SRC_FORCED = 14;
   localparam int SRC_TOTAL = 15;
   // queue default depth
   localparam int QUEUE_DEPTH = 8;
   localparam int FRAME_BITS = 64;
endpackage

// *** verilog/efb_queue.sv ***
// efb_queue: small flip-flop fifo of assembled emergency payloads.
// assumes one clock; writer checks full, reader checks empty.
`timescale 1ns/1ps
module efb_queue #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 8
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic push_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic pop_in,
   output logic [WIDTH-1:0] head_out,
   output logic full_out,
   output logic empty_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_push;
   logic do_pop;

   // pushes into a full queue are dropped, so the writer must hold until room
   assign do_push = push_in && !full_out;
   assign do_pop = pop_in && (count != '0);
   assign full_out = (count == (AW+1)'(DEPTH));
   assign empty_out = (count == '0);
   assign head_out = store[rd_ptr];

   // storage write
   always_ff @(posedge clk_in) begin
      if (do_push) begin
         store[wr_ptr] <= push_data_in;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
         end
         if (do_pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
         end
         if (do_push && !do_pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (do_pop && !do_push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end
endmodule

// *** bench/efb_builder_sva.sv ***
// efb_builder_sva: port-level checks of the emergency frame builder.
// assumes it is bound to efb_builder and sees only that module's ports.
`timescale 1ns/1ps
module efb_builder_sva (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [6:0] node_id_in,
   input wire logic init_done_in,
   input wire logic ev_supply_high_in,
   input wire logic ev_guard_fail_in,
   input wire logic ev_ready_out,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire logic [10:0] tx_id_out,
   input wire logic [3:0] tx_dlc_out,
   input wire logic [63:0] tx_data_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // an offered emergency frame, and one the controller is stalling
   sequence s_emcy;
      tx_valid_out && tx_dlc_out == 4'h8;
   endsequence
   sequence s_stall;
      tx_valid_out && !tx_ready_in;
   endsequence
   sequence s_idle_event;
      ev_ready_out && (ev_supply_high_in || ev_guard_fail_in) && !tx_valid_out && init_done_in;
   endsequence
   property p_emcy_id;
      s_emcy |-> tx_id_out == efb_pkg::EMCY_ID_BASE + {4'h0, node_id_in};
   endproperty
   property p_dlc;
      tx_valid_out |-> tx_dlc_out == 4'h8 || tx_dlc_out == 4'h1;
   endproperty
   property p_boot;
      tx_valid_out && tx_dlc_out == 4'h1 |->
         tx_id_out == efb_pkg::GUARD_ID_BASE + {4'h0, node_id_in} && tx_data_out == 64'h0;
   endproperty
   property p_hold;
      s_stall |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_id_out);
   endproperty
   // only code 7000 may use the last two bytes
   property p_tail;
      s_emcy and tx_data_out[15:0] != 16'h7000 |-> tx_data_out[63:48] == 16'h0000;
   endproperty
   property p_volt;
      s_emcy and tx_data_out[15:12] == 4'h3 |-> tx_data_out[23:16] == 8'h04;
   endproperty
   property p_comm;
      s_emcy and tx_data_out[15:8] == 8'h81 |->
         tx_data_out[23:16] == 8'h10 && tx_data_out[63:32] == 32'h0;
   endproperty
   // queue stage plus frame stage: the frame shows on the second edge
   property p_answer;
      s_idle_event |-> ##[1:3] tx_valid_out;
   endproperty
   a_emcy_id: assert property (p_emcy_id) else $error("emergency id wrong");
   a_dlc: assert property (p_dlc) else $error("frame length wrong");
   a_boot: assert property (p_boot) else $error("boot-up frame wrong");
   a_hold: assert property (p_hold) else $error("frame changed while stalled");
   a_tail: assert property (p_tail) else $error("bytes 6 and 7 not zero");
   a_volt: assert property (p_volt) else $error("voltage error register wrong");
   a_comm: assert property (p_comm) else $error("comm frame wrong");
   a_answer: assert property (p_answer) else $error("event not sent");
endmodule
bind efb_builder efb_builder_sva efb_builder_sva_inst (.clk_in(clk_in),
   .resetn_in(resetn_in), .node_id_in(node_id_in), .init_done_in(init_done_in),
   .ev_supply_high_in(ev_supply_high_in), .ev_guard_fail_in(ev_guard_fail_in),
   .ev_ready_out(ev_ready_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
   .tx_id_out(tx_id_out), .tx_dlc_out(tx_dlc_out), .tx_data_out(tx_data_out));

// *** bench/efb_can_sink.sv ***
// efb_can_sink: behavioural CAN controller taking frames from the builder.
// assumes one clock; ready moves on the falling edge, frames are taken on the rising.
`timescale 1ns/1ps
module efb_can_sink (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic slow_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [10:0] tx_id_in,
   input wire logic [3:0] tx_dlc_in,
   input wire logic [63:0] tx_data_in,
   output logic got_out,
   output logic [78:0] frame_out
);
   logic [1:0] cnt = 2'h0;
   initial tx_ready_out = 1'h0;
   // slow mode takes one frame in four cycles so the builder queue backs up
   always @(negedge clk_in) begin
      cnt <= cnt + 2'h1;
      tx_ready_out <= !slow_in || cnt == 2'h3;
   end
   // a taken frame is shown for one cycle
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         got_out <= 1'h0;
      end else begin
         got_out <= tx_valid_in && tx_ready_out;
         frame_out <= {tx_id_in, tx_dlc_in, tx_data_in};
      end
   end
endmodule

// *** bench/test_emergency_frame_builder.sv ***
// test_emergency_frame_builder: random and corner events, every frame scored.
// assumes efb_pkg, the builder, its checker and the frame sink are compiled first.
`timescale 1ns/1ps
module test_emergency_frame_builder;
   logic clk_in, resetn_in, init_done, slow, gw, sw, got, saw_full;
   logic ev_ready, tx_valid, tx_ready;
   logic [14:0] ev;
   logic [6:0] node;
   logic [7:0] mod, chn;
   logic [63:0] diag, tx_data;
   logic [10:0] tx_id;
   logic [3:0] tx_dlc;
   logic [78:0] frame;
   logic [78:0] exp_q[$];
   int seed = 27284;
   int failures = 0;
   int tests_run = 0;
   efb_builder efb_builder_inst (.clk_in(clk_in), .resetn_in(resetn_in), .node_id_in(node),
      .init_done_in(init_done), .ev_supply_high_in(ev[0]), .ev_supply_low_in(ev[1]),
      .ev_field_low_in(ev[2]), .ev_module_diag_in(ev[3]), .ev_module_err_in(ev[4]),
      .ev_diag_change_in(ev[5]), .ev_list_adapt_in(ev[6]), .ev_list_incompat_in(ev[7]),
      .ev_list_expand_in(ev[8]), .ev_list_removed_in(ev[9]), .ev_can_warning_in(ev[10]),
      .ev_tx_timeout_in(ev[11]), .ev_guard_fail_in(ev[12]), .ev_bus_off_left_in(ev[13]),
      .forced_output_mode_in(ev[14]), .gateway_source_in(gw), .single_wire_in(sw),
      .module_in(mod), .channel_in(chn), .diag_in(diag), .ev_ready_out(ev_ready),
      .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_id_out(tx_id),
      .tx_dlc_out(tx_dlc), .tx_data_out(tx_data));
   efb_can_sink efb_can_sink_inst (.clk_in(clk_in), .resetn_in(resetn_in), .slow_in(slow),
      .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_id_in(tx_id), .tx_dlc_in(tx_dlc),
      .tx_data_in(tx_data), .got_out(got), .frame_out(frame));
   always #50 clk_in = ~clk_in;
   // expected frame: id, length, info bytes 7..3, error register, then the code with
   // its low byte in byte 0
   function automatic logic [78:0] expect_frame(int src, logic g, logic s);
      logic [15:0] code;
      logic [7:0] er;
      logic [39:0] info;
      code = 16'h7010;
      er = 8'h80;
      info = {32'h0, mod};
      case (src)
         0: {code, er, info} = {16'h3110, 8'h04, 24'h0, g ? 8'h00 : chn, 8'h00};
         1: {code, er, info} = {16'h3120, 8'h04, 24'h0, g ? 8'h00 : chn, g ? 8'h00 : mod};
         2: {code, er, info} = {16'h3320, 8'h04, 24'h0, g ? 8'h00 : chn, g ? 8'h00 : mod};
         3: {code, info} = {16'h7000, s ? {diag[31:24] | diag[47:40] | diag[63:56],
            diag[23:16] | diag[39:32] | diag[55:48], diag[15:8], diag[7:0], mod} :
            {16'h0, diag[7:0], chn, mod}};
         4: er = 8'h81;
         5: {code, er} = {16'h7011, 8'h81};
         6: code = 16'h707A;
         7: code = 16'h707D;
         8: code = 16'h707E;
         9: code = 16'h707F;
         10: {code, er, info} = {16'h8100, 8'h10, 40'h02};
         11: {code, er, info} = {16'h8100, 8'h10, 40'h03};
         12: {code, er, info} = {16'h8130, 8'h10, 40'h0};
         13: {code, er, info} = {16'h8140, 8'h10, 40'h0};
         default: {code, info} = {16'h9009, 40'h0};
      endcase
      return {efb_pkg::EMCY_ID_BASE + {4'h0, node}, 4'h8, info, er, code[15:8], code[7:0]};
   endfunction
   // one event held until the builder has room, details random
   task automatic send_event(int src, logic g, logic s);
      int n;
      n = 0;
      @(negedge clk_in);
      mod = 8'($random(seed));
      chn = 8'($random(seed));
      diag = {$random(seed), $random(seed)};
      gw = g;
      sw = s;
      ev = {ev[14] | (src == 14), 14'(1 << src)};
      exp_q.push_back(expect_frame(src, g, s));
      while (ev_ready !== 1'h1 && n < 1000) begin
         @(negedge clk_in);
         n++;
      end
      @(posedge clk_in);
   endtask
   task automatic drain(string name);
      int n;
      n = 0;
      @(negedge clk_in);
      ev[13:0] = 14'h0;
      while (exp_q.size() != 0 && n < 2000) begin
         @(negedge clk_in);
         n++;
      end
      tests_run++;
      if (exp_q.size() != 0) begin
         failures++;
         $display("MISMATCH %0t frames missing", $time);
      end
      $display("test %s done", name);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // score frames in taken order; an extra frame counts against the design
   always @(negedge clk_in) begin
      if (got === 1'h1) begin
         tests_run++;
         if (exp_q.size() == 0 || frame !== exp_q[0]) begin
            failures++;
            $display("MISMATCH %0t frame %h", $time, frame);
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
      if (ev_ready === 1'h0) saw_full = 1'h1;
   end
   initial begin
      clk_in = 1'h0;
      resetn_in = 1'h0;
      init_done = 1'h1;
      slow = 1'h0;
      ev = 15'h0;
      {gw, sw, mod, chn, diag, saw_full} = 83'h0;
      node = 7'($random(seed)) | 7'h01;
      exp_q.push_back({efb_pkg::GUARD_ID_BASE + {4'h0, node}, 4'h1, 64'h0});
      repeat (16) @(negedge clk_in);
      resetn_in = 1'h1;
      for (int s = 0; s < 15; s++) send_event(s, 1'($random(seed)), 1'($random(seed)));
      send_event(0, 1'h1, 1'h0);
      send_event(1, 1'h1, 1'h0);
      send_event(2, 1'h0, 1'h0);
      send_event(3, 1'h0, 1'h1);
      send_event(3, 1'h0, 1'h0);
      drain("codes");
      // a slow controller fills the queue; held events must still all arrive
      slow = 1'h1;
      for (int i = 0; i < 24; i++) send_event(i % 14, 1'($random(seed)), 1'($random(seed)));
      drain("backlog");
      tests_run++;
      if (saw_full !== 1'h1) begin
         failures++;
         $display("MISMATCH %0t queue never filled", $time);
      end
      // a node reset in mid-run must bring one more boot-up frame before anything else
      slow = 1'h0;
      ev = 15'h0;
      resetn_in = 1'h0;
      exp_q.push_back({efb_pkg::GUARD_ID_BASE + {4'h0, node}, 4'h1, 64'h0});
      repeat (4) @(negedge clk_in);
      resetn_in = 1'h1;
      send_event(12, 1'h0, 1'h0);
      drain("node reset");
      complete_run();
   end
   // hang guard: the run needs well under a thousand cycles
   initial begin
      #2000000;
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      complete_run();
   end
endmodule
